// ===== rtl/bmc_consts.svh
`ifndef BMC_CONSTS_SVH
`define BMC_CONSTS_SVH

// Clock rate, used to turn printed times into cycle counts.
`define BMC_CLK_KHZ 40000
`define BMC_CLK_PERIOD_NS 25

// Number of buck regulators handled by the block.
`define BMC_NUM_BUCK 3
`define BMC_SYNC_BITS 12

// Overcurrent persistence time before the fault pulse.
`define BMC_OC_TIME_MS 8
`define BMC_OC_PERSIST_CYC (`BMC_OC_TIME_MS * `BMC_CLK_KHZ)

// Settling delay after regulation is reached during soft-start.
`define BMC_SS_SETTLE_MS 3
`define BMC_SS_SETTLE_CYC (`BMC_SS_SETTLE_MS * `BMC_CLK_KHZ)

// Duration of the PFM and APS phases of soft-start.
`define BMC_SS_PHASE_NS 100000
`define BMC_SS_PHASE_CYC (`BMC_SS_PHASE_NS / `BMC_CLK_PERIOD_NS)

// Long-press time of the power button in switch mode.
`define BMC_LONG_PRESS_S 4
`define BMC_LONG_PRESS_CYC (`BMC_LONG_PRESS_S * 1000 * `BMC_CLK_KHZ)

// Spacing between start-up sequence slots.
`define BMC_SEQ_SLOT_NS 100000
`define BMC_SEQ_SLOT_CYC (`BMC_SEQ_SLOT_NS / `BMC_CLK_PERIOD_NS)

// Set-point ramp: one code step per interval.
`define BMC_DVS_STEP_NS 4000
`define BMC_DVS_STEP_CYC (`BMC_DVS_STEP_NS / `BMC_CLK_PERIOD_NS)

// Mode field codes.
`define BMC_MF_OFF_OFF 4'h0
`define BMC_MF_PWM_OFF 4'h1
`define BMC_MF_PFM_OFF 4'h3
`define BMC_MF_APS_OFF 4'h4
`define BMC_MF_PWM_PWM 4'h5
`define BMC_MF_PWM_APS 4'h6
`define BMC_MF_APS_APS 4'h8
`define BMC_MF_APS_PFM 4'hc
`define BMC_MF_PWM_PFM 4'hd

`endif

// ===== rtl/bmc_pkg.sv
package bmc_pkg;

  // Power state machine states, one-hot.
  typedef enum logic [4:0] {
    BMC_PS_OFF   = 5'h01,
    BMC_PS_COIN  = 5'h02,
    BMC_PS_SLEEP = 5'h04,
    BMC_PS_STBY  = 5'h08,
    BMC_PS_ON    = 5'h10
  } bmc_pwr_e;

  // Switching mode selected for a regulator.
  typedef enum logic [1:0] {
    BMC_SEL_OFF = 2'h0,
    BMC_SEL_PWM = 2'h1,
    BMC_SEL_PFM = 2'h2,
    BMC_SEL_APS = 2'h3
  } bmc_sel_e;

  // Switching operation actually driven to the power stage.
  typedef enum logic [1:0] {
    BMC_OP_NONE = 2'h0,
    BMC_OP_PFM  = 2'h1,
    BMC_OP_SKIP = 2'h2,
    BMC_OP_PWM  = 2'h3
  } bmc_op_e;

  // Per-regulator start-up states, one-hot.
  typedef enum logic [6:0] {
    BMC_SS_IDLE   = 7'h01,
    BMC_SS_WAIT   = 7'h02,
    BMC_SS_PFM    = 7'h04,
    BMC_SS_APS    = 7'h08,
    BMC_SS_PWM    = 7'h10,
    BMC_SS_SETTLE = 7'h20,
    BMC_SS_RUN    = 7'h40
  } bmc_ss_e;

endpackage

// ===== rtl/bmc_pwr_button.sv
`timescale 1ns/10ps
`include "bmc_consts.svh"

module bmc_pwr_button #(
  parameter int unsigned LONG_PRESS_CYC = `BMC_LONG_PRESS_CYC
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_i,
  // Synchronised button level and its configuration.
  input wire logic button_i,
  input wire logic power_button_input_type_i,
  input wire logic long_press_off_enable_i,
  // Decoded events.
  output logic turn_on_o,
  output logic turn_off_o,
  output logic long_off_o
);

  logic button_q;
  logic [31:0] low_cnt;
  logic long_held;

  ////////////////////////////////////////////////////////////////////////////
  // Count how long the switch is held low; saturating keeps the flag level.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      button_q <= 1'b0;
      low_cnt <= 32'h0;
    end else begin
      button_q <= button_i;
      if (button_i || !power_button_input_type_i) begin
        low_cnt <= 32'h0;
      end else if (low_cnt <= LONG_PRESS_CYC) begin
        low_cnt <= low_cnt + 32'h1;
      end
    end
  end

  assign long_held = (low_cnt > LONG_PRESS_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // Active-high input turns on while high; a switch turns on at its press.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      turn_on_o <= 1'b0;
      turn_off_o <= 1'b0;
      long_off_o <= 1'b0;
    end else begin
      turn_on_o <= power_button_input_type_i ? (button_q && !button_i) : button_i;
      long_off_o <= long_held && long_press_off_enable_i;
      turn_off_o <= power_button_input_type_i ?
                    (long_held && long_press_off_enable_i) : !button_i;
    end
  end

  long_off_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    long_off_o |-> ($past(low_cnt) > LONG_PRESS_CYC) && $past(long_press_off_enable_i))
    else $error("long-press off raised before the hold time elapsed");

endmodule // bmc_pwr_button

// ===== rtl/bmc_buck_chan.sv
`timescale 1ns/10ps
`include "bmc_consts.svh"

module bmc_buck_chan import bmc_pkg::*; #(
  parameter int unsigned START_DELAY_CYC = 0,
  parameter int unsigned OC_PERSIST_CYC = `BMC_OC_PERSIST_CYC,
  parameter int unsigned SS_SETTLE_CYC = `BMC_SS_SETTLE_CYC
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_i,
  // Selected mode and analog indications (already synchronised).
  input wire bmc_sel_e sel_mode_i,
  input wire logic in_regulation_i,
  input wire logic load_heavy_i,
  input wire logic current_limit_i,
  // Power stage controls.
  output logic enable_o,
  output logic discharge_o,
  output bmc_op_e op_mode_o,
  output logic fault_o
);

  bmc_ss_e ss;
  bmc_ss_e next_ss;
  bmc_op_e next_op;
  logic [31:0] tmr;
  logic [31:0] oc_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // Start-up sequencing; a running regulator leaves RUN only when selected Off.
  always_comb begin
    next_ss = ss;
    case (ss)
      BMC_SS_IDLE: if (sel_mode_i != BMC_SEL_OFF) next_ss = BMC_SS_WAIT;
      BMC_SS_WAIT: if (tmr >= START_DELAY_CYC) next_ss = BMC_SS_PFM;
      BMC_SS_PFM: if (tmr >= `BMC_SS_PHASE_CYC) next_ss = BMC_SS_APS;
      BMC_SS_APS: if (tmr >= `BMC_SS_PHASE_CYC) next_ss = BMC_SS_PWM;
      BMC_SS_PWM: if (in_regulation_i) next_ss = BMC_SS_SETTLE;
      BMC_SS_SETTLE: if (tmr >= SS_SETTLE_CYC) next_ss = BMC_SS_RUN;
      BMC_SS_RUN: next_ss = BMC_SS_RUN;
      default: next_ss = BMC_SS_IDLE;
    endcase
    if (sel_mode_i == BMC_SEL_OFF) next_ss = BMC_SS_IDLE;
  end

  // Operation follows the state; only RUN honours the selected mode.
  always_comb begin
    case (next_ss)
      BMC_SS_PFM: next_op = BMC_OP_PFM;
      BMC_SS_APS: next_op = load_heavy_i ? BMC_OP_PWM : BMC_OP_SKIP;
      BMC_SS_PWM, BMC_SS_SETTLE: next_op = BMC_OP_PWM;
      BMC_SS_RUN: begin
        case (sel_mode_i)
          BMC_SEL_PWM: next_op = BMC_OP_PWM;
          BMC_SEL_PFM: next_op = BMC_OP_PFM;
          BMC_SEL_APS: next_op = load_heavy_i ? BMC_OP_PWM : BMC_OP_SKIP;
          default: next_op = BMC_OP_NONE;
        endcase
      end
      default: next_op = BMC_OP_NONE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State, phase timer and registered stage controls.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ss <= BMC_SS_IDLE;
      tmr <= 32'h0;
      enable_o <= 1'b0;
      discharge_o <= 1'b1;
      op_mode_o <= BMC_OP_NONE;
    end else begin
      ss <= next_ss;
      tmr <= (next_ss != ss) ? 32'h0 : tmr + 32'h1;
      enable_o <= (next_ss != BMC_SS_IDLE) && (next_ss != BMC_SS_WAIT);
      discharge_o <= (next_ss == BMC_SS_IDLE);
      op_mode_o <= next_op;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Persistence timer: any gap in the limit restarts it, so only a
  // continuous overcurrent faults; the pulse fires once per episode.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      oc_cnt <= 32'h0;
      fault_o <= 1'b0;
    end else begin
      if (!current_limit_i) begin
        oc_cnt <= 32'h0;
      end else if (oc_cnt <= OC_PERSIST_CYC) begin
        oc_cnt <= oc_cnt + 32'h1;
      end
      fault_o <= current_limit_i && (oc_cnt == OC_PERSIST_CYC);
    end
  end

  sequence ss_aps_s;
    ss == BMC_SS_APS;
  endsequence

  sequence ss_pfm_s;
    ss == BMC_SS_PFM;
  endsequence

  off_discharge_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (sel_mode_i == BMC_SEL_OFF) |=> (!enable_o && discharge_o && op_mode_o == BMC_OP_NONE))
    else $error("off mode did not disable and discharge");

  ss_order_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ss_pfm_s ##0 (sel_mode_i != BMC_SEL_OFF) ##1 (ss != BMC_SS_PFM) |-> ss_aps_s)
    else $error("soft-start skipped the APS phase");

  settle_delay_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(ss == BMC_SS_RUN) |-> $past(ss == BMC_SS_SETTLE) && ($past(tmr) >= SS_SETTLE_CYC))
    else $error("selected mode applied before settling delay");

  fixed_pwm_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ss == BMC_SS_RUN && $past(sel_mode_i) == BMC_SEL_PWM) |-> op_mode_o == BMC_OP_PWM)
    else $error("PWM selection not held in PWM");

  oc_fault_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    fault_o |-> $past(oc_cnt) == OC_PERSIST_CYC && $past(current_limit_i))
    else $error("fault pulse without persistent overcurrent");

  oc_restart_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    !current_limit_i |=> (oc_cnt == 32'h0) ##1 !fault_o)
    else $error("overcurrent timer not restarted");

endmodule // bmc_buck_chan

// ===== rtl/bmc_buck_mode_ctrl.sv
// Contract
// - Undervoltage sends the state machine to Coin Cell.
// - Overcurrent lasting over 8 ms raises fault.
// - Mode changes on writes, standby, sleep, load.
// - Off mode disables regulator and discharges output.
// - PWM or PFM selection holds regardless of load.
// - APS switches skip/PWM from load indication.
// - Soft-start steps PFM, APS, then PWM.
// - After regulation, wait 3 ms, apply mode.
// - Decode codes 0,1,3,4 for Normal/Standby.
// - Decode codes 5,6,8,c,d; others reserved.
// - Standby uses standby set point and column.
// - Leaving standby restores normal mode and set point.
// - Set-point changes ramp at the DVS step rate.
// - Normal and standby set points share coding.
// - Turn-off: keep-on regulators sleep, others off.
// - Sleeping regulators use sleep set point, PFM.
// - Turn-on event moves Sleep to ON.
// - Kept-on regulators continue without restart on wake.
// - Others restart at their sequence slot.
// - Sleep set point: core 6-bit, others 7-bit.
// - Turn-off: active-high low, or long press.
// - Standby set point: core 6-bit, others 7-bit.
`timescale 1ns/10ps
`include "bmc_consts.svh"

module bmc_buck_mode_ctrl import bmc_pkg::*; #(
  parameter int unsigned LONG_PRESS_CYC = `BMC_LONG_PRESS_CYC,
  parameter int unsigned OC_PERSIST_CYC = `BMC_OC_PERSIST_CYC,
  parameter int unsigned SS_SETTLE_CYC = `BMC_SS_SETTLE_CYC,
  parameter int unsigned SEQ_SLOT_CYC = `BMC_SEQ_SLOT_CYC
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_i,
  // Pins from outside the clock domain.
  input wire logic input_undervoltage_detect_i,
  input wire logic power_button_input_i,
  input wire logic standby_i,
  input wire logic [2:0] current_limit_i,
  input wire logic [2:0] in_regulation_i,
  input wire logic [2:0] load_heavy_i,
  // Configuration bits.
  input wire logic power_button_input_type_i,
  input wire logic long_press_off_enable_i,
  input wire logic [11:0] buck_switching_mode_field_i,
  input wire logic [2:0] sleep_keep_on_bit_i,
  // Core buck pair set points.
  input wire logic [5:0] core_buck_normal_setpoint_i,
  input wire logic [5:0] core_buck_standby_setpoint_i,
  input wire logic [5:0] core_buck_sleep_setpoint_i,
  // Second buck [6:0] and third buck pair [13:7] set points.
  input wire logic [13:0] buck_normal_setpoint_i,
  input wire logic [13:0] buck_standby_setpoint_i,
  input wire logic [13:0] buck_sleep_setpoint_i,
  // State and regulator controls.
  output logic [4:0] power_state_o,
  output logic [2:0] reg_enable_o,
  output logic [2:0] discharge_o,
  output logic [5:0] switch_op_o,
  output logic [2:0] fault_o,
  output logic [5:0] core_buck_target_o,
  output logic [6:0] second_buck_target_o,
  output logic [6:0] third_buck_target_o
);

  logic [11:0] sync_raw;
  logic [11:0] sync1;
  logic [11:0] sync2;
  logic uv_s;
  logic button_s;
  logic stby_s;
  logic turn_on;
  logic turn_off;
  logic long_off;
  bmc_pwr_e pwr_state;
  bmc_pwr_e next_pwr_state;
  bmc_sel_e sel_mode [3];
  logic [6:0] desired_sp [3];
  logic [6:0] cur_sp [3];
  logic [7:0] dvs_cnt [3];

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the mode field; reserved codes fall to Off/Off so that no
  // undefined switching mode can ever reach the stage.
  function automatic bmc_sel_e bmc_decode(input logic [3:0] field, input logic stby);
    bmc_sel_e norm;
    bmc_sel_e sb;
    norm = BMC_SEL_OFF;
    sb = BMC_SEL_OFF;
    case (field)
      `BMC_MF_OFF_OFF: norm = BMC_SEL_OFF;
      `BMC_MF_PWM_OFF: norm = BMC_SEL_PWM;
      `BMC_MF_PFM_OFF: norm = BMC_SEL_PFM;
      `BMC_MF_APS_OFF: norm = BMC_SEL_APS;
      `BMC_MF_PWM_PWM: begin
        norm = BMC_SEL_PWM;
        sb = BMC_SEL_PWM;
      end
      `BMC_MF_PWM_APS: begin
        norm = BMC_SEL_PWM;
        sb = BMC_SEL_APS;
      end
      `BMC_MF_APS_APS: begin
        norm = BMC_SEL_APS;
        sb = BMC_SEL_APS;
      end
      `BMC_MF_APS_PFM: begin
        norm = BMC_SEL_APS;
        sb = BMC_SEL_PFM;
      end
      `BMC_MF_PWM_PFM: begin
        norm = BMC_SEL_PWM;
        sb = BMC_SEL_PFM;
      end
      default: begin
        norm = BMC_SEL_OFF;
        sb = BMC_SEL_OFF;
      end
    endcase
    return stby ? sb : norm;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers for every asynchronous pin.
  assign sync_raw = {load_heavy_i, in_regulation_i, current_limit_i,
                     standby_i, power_button_input_i, input_undervoltage_detect_i};

  genvar g;
  generate
    for (g = 0; g < `BMC_SYNC_BITS; g++) begin : g_sync
      always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
          sync1[g] <= 1'b0;
          sync2[g] <= 1'b0;
        end else begin
          sync1[g] <= sync_raw[g];
          sync2[g] <= sync1[g];
        end
      end
    end
  endgenerate

  assign uv_s = sync2[0];
  assign button_s = sync2[1];
  assign stby_s = sync2[2];

  // Power button event decoding.
  bmc_pwr_button #(
    .LONG_PRESS_CYC(LONG_PRESS_CYC)
  ) u_button (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .button_i(button_s),
    .power_button_input_type_i(power_button_input_type_i),
    .long_press_off_enable_i(long_press_off_enable_i),
    .turn_on_o(turn_on),
    .turn_off_o(turn_off),
    .long_off_o(long_off)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Power state machine; undervoltage overrides every other transition.
  always_comb begin
    next_pwr_state = pwr_state;
    case (pwr_state)
      BMC_PS_OFF: if (turn_on) next_pwr_state = BMC_PS_ON;
      BMC_PS_COIN: if (!uv_s) next_pwr_state = BMC_PS_OFF;
      BMC_PS_SLEEP: begin
        if (long_off) begin
          next_pwr_state = BMC_PS_OFF;
        end else if (turn_on) begin
          next_pwr_state = BMC_PS_ON;
        end
      end
      BMC_PS_STBY: begin
        if (turn_off) begin
          next_pwr_state = (|sleep_keep_on_bit_i) ? BMC_PS_SLEEP : BMC_PS_OFF;
        end else if (!stby_s) begin
          next_pwr_state = BMC_PS_ON;
        end
      end
      BMC_PS_ON: begin
        if (turn_off) begin
          next_pwr_state = (|sleep_keep_on_bit_i) ? BMC_PS_SLEEP : BMC_PS_OFF;
        end else if (stby_s) begin
          next_pwr_state = BMC_PS_STBY;
        end
      end
      default: next_pwr_state = BMC_PS_OFF;
    endcase
    if (uv_s) next_pwr_state = BMC_PS_COIN;
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pwr_state <= BMC_PS_OFF;
    end else begin
      pwr_state <= next_pwr_state;
    end
  end

  assign power_state_o = pwr_state;

  ////////////////////////////////////////////////////////////////////////////
  // Per-regulator mode selection, set-point choice, ramp and channel.
  generate
    for (g = 0; g < `BMC_NUM_BUCK; g++) begin : g_buck
      logic [6:0] norm_sp;
      logic [6:0] stby_sp;
      logic [6:0] sleep_sp;
      bmc_op_e op;

      // The core pair codes are narrower and sit in the low bits.
      if (g == 0) begin : g_core
        assign norm_sp = {1'b0, core_buck_normal_setpoint_i};
        assign stby_sp = {1'b0, core_buck_standby_setpoint_i};
        assign sleep_sp = {1'b0, core_buck_sleep_setpoint_i};
      end else begin : g_wide
        assign norm_sp = buck_normal_setpoint_i[7*g-1 -: 7];
        assign stby_sp = buck_standby_setpoint_i[7*g-1 -: 7];
        assign sleep_sp = buck_sleep_setpoint_i[7*g-1 -: 7];
      end

      // Mode and target for the current power state.
      always_comb begin
        case (pwr_state)
          BMC_PS_ON: begin
            sel_mode[g] = bmc_decode(buck_switching_mode_field_i[4*g+3 -: 4], 1'b0);
            desired_sp[g] = norm_sp;
          end
          BMC_PS_STBY: begin
            sel_mode[g] = bmc_decode(buck_switching_mode_field_i[4*g+3 -: 4], 1'b1);
            desired_sp[g] = stby_sp;
          end
          BMC_PS_SLEEP: begin
            sel_mode[g] = sleep_keep_on_bit_i[g] ? BMC_SEL_PFM : BMC_SEL_OFF;
            desired_sp[g] = sleep_sp;
          end
          default: begin
            sel_mode[g] = BMC_SEL_OFF;
            desired_sp[g] = norm_sp;
          end
        endcase
      end

      // A disabled regulator snaps to its target so that start-up begins at
      // the right code; a running one moves one code per step interval.
      always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
          cur_sp[g] <= 7'h0;
          dvs_cnt[g] <= 8'h0;
        end else if (!reg_enable_o[g]) begin
          cur_sp[g] <= desired_sp[g];
          dvs_cnt[g] <= 8'h0;
        end else if (cur_sp[g] == desired_sp[g]) begin
          dvs_cnt[g] <= 8'h0;
        end else if (dvs_cnt[g] == 8'(`BMC_DVS_STEP_CYC - 1)) begin
          dvs_cnt[g] <= 8'h0;
          cur_sp[g] <= (cur_sp[g] < desired_sp[g]) ? cur_sp[g] + 7'h1
                                                   : cur_sp[g] - 7'h1;
        end else begin
          dvs_cnt[g] <= dvs_cnt[g] + 8'h1;
        end
      end

      bmc_buck_chan #(
        .START_DELAY_CYC(g * SEQ_SLOT_CYC),
        .OC_PERSIST_CYC(OC_PERSIST_CYC),
        .SS_SETTLE_CYC(SS_SETTLE_CYC)
      ) u_chan (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .sel_mode_i(sel_mode[g]),
        .in_regulation_i(sync2[6+g]),
        .load_heavy_i(sync2[9+g]),
        .current_limit_i(sync2[3+g]),
        .enable_o(reg_enable_o[g]),
        .discharge_o(discharge_o[g]),
        .op_mode_o(op),
        .fault_o(fault_o[g])
      );

      assign switch_op_o[2*g+1 -: 2] = op;

      sleep_pfm_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (pwr_state == BMC_PS_SLEEP && sleep_keep_on_bit_i[g]) |->
          (sel_mode[g] == BMC_SEL_PFM && desired_sp[g] == sleep_sp))
        else $error("kept-on regulator not in PFM at sleep set point");

      dvs_step_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (reg_enable_o[g] && $past(reg_enable_o[g]) && cur_sp[g] != $past(cur_sp[g])) |->
          ($past(dvs_cnt[g]) == 8'(`BMC_DVS_STEP_CYC - 1)))
        else $error("set point moved faster than the step rate");

      reserved_off_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (pwr_state == BMC_PS_ON && buck_switching_mode_field_i[4*g+3 -: 4] inside {4'h2, 4'h7}) |->
          sel_mode[g] == BMC_SEL_OFF)
        else $error("reserved mode code not treated as off");
    end
  endgenerate

  assign core_buck_target_o = cur_sp[0][5:0];
  assign second_buck_target_o = cur_sp[1];
  assign third_buck_target_o = cur_sp[2];

  ////////////////////////////////////////////////////////////////////////////
  // State machine checks.
  coin_entry_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    uv_s |=> pwr_state == BMC_PS_COIN)
    else $error("undervoltage did not reach coin cell");

  wake_sleep_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (pwr_state == BMC_PS_SLEEP && turn_on && !long_off && !uv_s) |=> pwr_state == BMC_PS_ON)
    else $error("turn-on did not leave sleep");

  off_split_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (pwr_state == BMC_PS_ON && turn_off && !uv_s && sleep_keep_on_bit_i == 3'h0) |=>
      pwr_state == BMC_PS_OFF)
    else $error("turn-off without kept-on regulators did not power off");

  stby_exit_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (pwr_state == BMC_PS_STBY && !stby_s && !turn_off && !uv_s) |=> pwr_state == BMC_PS_ON)
    else $error("standby release did not return to on");

endmodule // bmc_buck_mode_ctrl

// ===== tb/bmc_stage_model.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module bmc_stage_model #(
  parameter int unsigned RISE_CYC = 40
) (
  // Clock and stage enables.
  input wire logic mclk_i,
  input wire logic [2:0] enable_i,
  // Regulation flags back to the block.
  output logic [2:0] in_regulation_o
);
  int cnt [3] = '{0, 0, 0};
  // An output needs time to charge, and loses regulation at once when disabled.
  always @(posedge mclk_i) begin
    for (int g = 0; g < 3; g++) begin
      cnt[g] <= enable_i[g] ? cnt[g] + 1 : 0;
      in_regulation_o[g] <= enable_i[g] && cnt[g] >= RISE_CYC;
    end
  end
endmodule // bmc_stage_model

// ===== tb/testbench.sv
`timescale 1ns/10ps
module testbench import bmc_pkg::*;;
  localparam logic [31:0] NRM = 32'h07031784; // Normal column, 2 bits per code.
  localparam logic [31:0] STB = 32'h0a033400; // Standby column.
  logic mclk_i = 0, rst_i = 1, uv = 0, btn = 0, stby = 0, sw = 0, lpe = 0;
  logic [2:0] oc = 0, heavy = 0, keep = 3'b001, inreg, en, dis, flt;
  logic [11:0] mode = 12'h033;
  logic [4:0] st;
  logic [5:0] op, tc, cn, cs, cz;
  logic [6:0] ts, tt;
  logic [13:0] bn;
  logic [31:0] seed = 32'h18ac9e1b;
  logic [3:0] codes [8] = '{4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'hc, 4'hd};
  int err_total = 0, compares = 0, fcnt = 0;
  bmc_buck_mode_ctrl #(.LONG_PRESS_CYC(50), .OC_PERSIST_CYC(20), .SS_SETTLE_CYC(30),
    .SEQ_SLOT_CYC(10)) bmc_buck_mode_ctrl_i (.mclk_i(mclk_i), .rst_i(rst_i),
    .input_undervoltage_detect_i(uv), .power_button_input_i(btn), .standby_i(stby),
    .current_limit_i(oc), .in_regulation_i(inreg), .load_heavy_i(heavy),
    .power_button_input_type_i(sw), .long_press_off_enable_i(lpe),
    .buck_switching_mode_field_i(mode), .sleep_keep_on_bit_i(keep),
    .core_buck_normal_setpoint_i(cn), .core_buck_standby_setpoint_i(cs),
    .core_buck_sleep_setpoint_i(cz), .buck_normal_setpoint_i(bn),
    .buck_standby_setpoint_i(bn), .buck_sleep_setpoint_i(bn), .power_state_o(st),
    .reg_enable_o(en), .discharge_o(dis), .switch_op_o(op), .fault_o(flt),
    .core_buck_target_o(tc), .second_buck_target_o(ts), .third_buck_target_o(tt));
  bmc_stage_model bmc_stage_model_i (.mclk_i(mclk_i), .enable_i(en), .in_regulation_o(inreg));
  initial forever #12.5 mclk_i = ~mclk_i;
  // Fault pulses of the core pair are counted so episodes can be told apart.
  always @(negedge mclk_i) if (flt[0] === 1'b1) fcnt++;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Operation expected at the stage: APS follows the load, Off drives nothing.
  function automatic logic [1:0] exp_op(input logic [3:0] c, input logic s, input logic h);
    logic [1:0] sel;
    sel = s ? STB[2*c+:2] : NRM[2*c+:2];
    return sel == 2'h0 ? 2'h0 : sel == 2'h1 ? 2'h3 : sel == 2'h2 ? 2'h1 : {1'b1, h};
  endfunction
  task automatic chk(input logic [6:0] got, input logic [6:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task automatic wait_op(input logic [1:0] v, input int lim);
    for (int k = 0; k < lim && op[1:0] !== v; k++) tick(1);
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // The run needs about ten thousand cycles, so forty thousand means a hang.
  initial begin
    #1000000;
    err_total++;
    print_verdict();
  end
  initial begin
    seed = lfsr(seed);
    {bn, cn} = seed[19:0];
    cs = cn + 6'h2;
    cz = cn + 6'h1;
    tick(5);
    rst_i = 0;
    tick(3);
    chk(7'(st), 7'(BMC_PS_OFF));
    chk(7'(dis), 7'h7);
    chk(ts, bn[6:0]);
    chk(tt, bn[13:7]);
    chk(7'({flt, op[5:2]}), 7'h0);
    btn = 1;
    for (int k = 0; k < 60 && en[0] !== 1'b1; k++) tick(1);
    chk(7'(op[1:0]), 7'(BMC_OP_PFM));
    wait_op(2'h3, 9000);
    chk(7'(op[1:0]), 7'(BMC_OP_PWM));
    wait_op(2'h1, 200);
    chk(7'(op[1:0]), 7'(BMC_OP_PFM));
    $display("soft-start test done");
    foreach (codes[i]) begin
      seed = lfsr(seed);
      heavy = seed[2:0];
      mode[3:0] = codes[i];
      tick(6);
      chk(7'(op[1:0]), 7'(exp_op(codes[i], 1'b0, heavy[0])));
    end
    stby = 1;
    tick(6);
    chk(7'(st), 7'(BMC_PS_STBY));
    tick(20);
    chk(7'(tc === cs), 7'h0);
    tick(400);
    chk(7'(tc), 7'(cs));
    chk(7'(op[1:0]), 7'(exp_op(4'hd, 1'b1, heavy[0])));
    stby = 0;
    tick(400);
    chk(7'(tc), 7'(cn));
    chk(7'(op[1:0]), 7'(exp_op(4'hd, 1'b0, heavy[0])));
    $display("standby test done");
    oc[0] = 1;
    tick(16);
    oc[0] = 0;
    tick(2);
    oc[0] = 1;
    tick(16);
    oc[0] = 0;
    tick(4);
    chk(7'(fcnt), 7'h0);
    oc[0] = 1;
    tick(40);
    oc[0] = 0;
    tick(4);
    chk(7'(fcnt), 7'h1);
    $display("overcurrent test done");
    btn = 0;
    tick(8);
    chk(7'(st), 7'(BMC_PS_SLEEP));
    tick(400);
    chk({en[1:0], op[1:0], tc[2:0]}, {2'b01, 2'h1, cz[2:0]});
    btn = 1;
    tick(8);
    chk(7'(st), 7'(BMC_PS_ON));
    chk(7'(en[1:0]), 7'h1);
    tick(6);
    chk(7'(op[1:0]), 7'(exp_op(4'hd, 1'b0, heavy[0])));
    $display("sleep test done");
    mode[3:0] = 4'h7;
    tick(6);
    chk(7'({en[0], dis[0]}), 7'h1);
    chk(7'(en[1]), 7'h1);
    uv = 1;
    tick(6);
    chk(7'(st), 7'(BMC_PS_COIN));
    $display("reserved and undervoltage test done");
    // Switch input: a press turns on, a long hold with no kept-on regulator powers off.
    uv = 0;
    sw = 1;
    lpe = 1;
    keep = 3'h0;
    tick(6);
    chk(7'(st), 7'(BMC_PS_OFF));
    btn = 0;
    tick(8);
    chk(7'(st), 7'(BMC_PS_ON));
    tick(60);
    chk(7'(st), 7'(BMC_PS_OFF));
    $display("switch test done");
    print_verdict();
  end
endmodule // testbench
